/* File: hdl/pch_defines.svh */
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH
// Register byte addresses
`define PCH_A_CMD_HEAD 8'h00
`define PCH_A_CMD_VALUE 8'h04
`define PCH_A_CMD_CHECK 8'h08
`define PCH_A_CONFIG 8'h0C
`define PCH_A_STATUS 8'h10
`define PCH_A_REP_STATUS 8'h14
`define PCH_A_REP_VALUE 8'h18
`define PCH_A_ACCU 8'h1C
`define PCH_A_POINT_IDX 8'h20
`define PCH_A_POINT_DATA 8'h24
// Instruction codes and types
`define PCH_OP_MOVE 8'h04
`define PCH_OP_SET_AXIS 8'h05
`define PCH_OP_GET_AXIS 8'h06
`define PCH_OP_SET_GLOBAL 8'h09
`define PCH_OP_GET_GLOBAL 8'h0A
`define PCH_MOVE_STORED 8'h02
// Banks and global parameter numbers
`define PCH_BANK_MODULE 8'h00
`define PCH_BANK_USER 8'h02
`define PCH_BANK_IRQ 8'h03
`define PCH_GP_SERIAL 8'h42
`define PCH_SERIAL_RST 8'h01
`define PCH_POINT_MAX 32'h0000_0014
// Reply status codes
`define PCH_ST_OK 8'h64
`define PCH_ST_CHECKSUM 8'h01
`define PCH_ST_BAD_CMD 8'h02
`define PCH_ST_BAD_TYPE 8'h03
`define PCH_ST_BAD_VALUE 8'h04
// Parameter memory regions
`define PCH_RG_AXIS 3'h0
`define PCH_RG_G0 3'h1
`define PCH_RG_G2 3'h2
`define PCH_RG_G3 3'h3
`define PCH_RG_POINT 3'h4
`define PCH_MEM_AW 11
`define PCH_MEM_DEPTH 2048
// AXI responses
`define PCH_RESP_OKAY 2'h0
`define PCH_RESP_SLVERR 2'h2
`endif

/* File: hdl/pch_pkg.sv */
package pch_pkg;
   typedef logic [31:0] pch_word_t;
   typedef logic [7:0] pch_byte_t;
   typedef enum logic [2:0] {
      PCH_IDLE = 3'b001,
      PCH_EXEC = 3'b010,
      PCH_FETCH = 3'b100
   } pch_state_t;
   typedef enum logic [1:0] {
      PCH_FK_AXIS = 2'h0,
      PCH_FK_GLOBAL = 2'h1,
      PCH_FK_MOVE = 2'h2
   } pch_fetch_t;
   typedef struct packed {
      pch_state_t state;
      pch_fetch_t kind;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      pch_word_t wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      pch_word_t rdata;
      logic [1:0] rresp;
      pch_word_t cmd_head;
      pch_word_t cmd_value;
      pch_byte_t cmd_sum;
      logic standalone;
      logic reply_valid;
      logic ignored;
      pch_byte_t serial;
      pch_byte_t rep_status;
      pch_word_t rep_value;
      pch_word_t accu;
      pch_byte_t point_idx;
      logic nv_valid;
      pch_byte_t nv_index;
      pch_word_t nv_data;
      logic move_start;
      pch_word_t move_target;
   } pch_top_st_t;
   typedef struct packed {
      pch_word_t rdata;
   } pch_mem_st_t;
endpackage : pch_pkg

/* File: hdl/pch_param_mem.sv */
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_param_mem (
   input wire logic clk,
   input wire logic we,
   input wire logic [`PCH_MEM_AW-1:0] waddr,
   input wire pch_pkg::pch_word_t wdata,
   input wire logic [`PCH_MEM_AW-1:0] raddr,
   output pch_pkg::pch_word_t rdata
);
   import pch_pkg::*;
   // Plain SRAM: contents are volatile and undefined until written
   pch_word_t mem [`PCH_MEM_DEPTH];
   pch_mem_st_t st;
   pch_mem_st_t nx;

   always_comb begin
      nx = st;
      nx.rdata = mem[raddr];
   end

   always_ff @(posedge clk) begin
      st <= nx;
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = st.rdata;
endmodule : pch_param_mem

/* File: hdl/pch_top.sv */
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire pch_pkg::pch_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output pch_pkg::pch_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic nv_save_valid,
   output pch_pkg::pch_byte_t nv_save_index,
   output pch_pkg::pch_word_t nv_save_data,
   output logic move_start,
   output pch_pkg::pch_word_t move_target
);
   import pch_pkg::*;

   function automatic pch_word_t merge(input pch_word_t old, input pch_word_t nw,
                                       input logic [3:0] strb);
      pch_word_t r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic bank_ok(input pch_byte_t b);
      return (b == `PCH_BANK_MODULE) || (b == `PCH_BANK_USER) || (b == `PCH_BANK_IRQ);
   endfunction : bank_ok

   function automatic logic [2:0] bank_region(input pch_byte_t b);
      case (b)
         `PCH_BANK_MODULE: return `PCH_RG_G0;
         `PCH_BANK_USER: return `PCH_RG_G2;
         default: return `PCH_RG_G3;
      endcase
   endfunction : bank_region

   logic [1:0] rst_sync;
   logic rst_n;
   pch_top_st_t st;
   pch_top_st_t nx;
   logic mem_we;
   logic [`PCH_MEM_AW-1:0] mem_waddr;
   pch_word_t mem_wdata;
   logic [`PCH_MEM_AW-1:0] mem_raddr;
   pch_word_t rd_data;
   pch_byte_t c_addr;
   pch_byte_t c_op;
   pch_byte_t c_type;
   pch_byte_t c_bank;
   pch_byte_t c_sum;

   // Release of reset is synchronised; assertion stays asynchronous
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Head word packs address, instruction, type and motor or bank bytes
   assign c_addr = st.cmd_head[31:24];
   assign c_op = st.cmd_head[23:16];
   assign c_type = st.cmd_head[15:8];
   assign c_bank = st.cmd_head[7:0];
   assign c_sum = 8'(c_addr + c_op + c_type + c_bank + st.cmd_value[31:24]
                     + st.cmd_value[23:16] + st.cmd_value[15:8] + st.cmd_value[7:0]);

   pch_param_mem u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(rd_data)
   );

   always_comb begin
      nx = st;
      mem_we = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      mem_raddr = '0;
      nx.nv_valid = 1'b0;
      nx.move_start = 1'b0;
      // Write address and data are taken independently, then paired
      if (s_axi_awvalid && st.awready) begin
         nx.aw_got = 1'b1;
         nx.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         nx.w_got = 1'b1;
         nx.wdata = s_axi_wdata;
         nx.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         nx.bvalid = 1'b0;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         nx.aw_got = 1'b0;
         nx.w_got = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp = `PCH_RESP_OKAY;
         case (st.awaddr)
            `PCH_A_CMD_HEAD: nx.cmd_head = merge(st.cmd_head, st.wdata, st.wstrb);
            `PCH_A_CMD_VALUE: nx.cmd_value = merge(st.cmd_value, st.wdata, st.wstrb);
            `PCH_A_CMD_CHECK: begin
               // A launch while a command is running is dropped
               if (st.state == PCH_IDLE) begin
                  nx.cmd_sum = st.wdata[7:0];
                  nx.state = PCH_EXEC;
                  nx.reply_valid = 1'b0;
               end
            end
            `PCH_A_CONFIG: nx.standalone = st.wdata[0];
            `PCH_A_POINT_IDX: nx.point_idx = st.wdata[7:0];
            `PCH_A_POINT_DATA: begin
               // Shares the memory write port, so only taken while idle
               if (st.state == PCH_IDLE) begin
                  mem_we = 1'b1;
                  mem_waddr = {`PCH_RG_POINT, st.point_idx};
                  mem_wdata = st.wdata;
               end
            end
            `PCH_A_STATUS, `PCH_A_REP_STATUS, `PCH_A_REP_VALUE, `PCH_A_ACCU: ;
            default: nx.bresp = `PCH_RESP_SLVERR;
         endcase
      end
      nx.awready = !nx.aw_got && !nx.bvalid;
      nx.wready = !nx.w_got && !nx.bvalid;

      if (st.rvalid && s_axi_rready) begin
         nx.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.arready) begin
         nx.rvalid = 1'b1;
         nx.rresp = `PCH_RESP_OKAY;
         case (s_axi_araddr)
            `PCH_A_CMD_HEAD: nx.rdata = st.cmd_head;
            `PCH_A_CMD_VALUE: nx.rdata = st.cmd_value;
            `PCH_A_CMD_CHECK: nx.rdata = {24'h0, st.cmd_sum};
            `PCH_A_CONFIG: nx.rdata = {31'h0, st.standalone};
            `PCH_A_STATUS: begin
               nx.rdata = {16'h0, st.serial, 5'h0, st.ignored, st.reply_valid,
                           (st.state != PCH_IDLE)};
            end
            `PCH_A_REP_STATUS: nx.rdata = {24'h0, st.rep_status};
            `PCH_A_REP_VALUE: nx.rdata = st.rep_value;
            `PCH_A_ACCU: nx.rdata = st.accu;
            `PCH_A_POINT_IDX: nx.rdata = {24'h0, st.point_idx};
            default: begin
               nx.rdata = 32'h0000_0000;
               nx.rresp = `PCH_RESP_SLVERR;
            end
         endcase
      end
      nx.arready = !nx.rvalid;

      case (st.state)
         PCH_IDLE: ;
         PCH_EXEC: begin
            nx.state = PCH_IDLE;
            nx.reply_valid = 1'b1;
            nx.ignored = 1'b0;
            nx.rep_value = 32'h0000_0000;
            nx.rep_status = `PCH_ST_OK;
            if (c_addr != st.serial) begin
               // Foreign traffic leaves no reply behind
               nx.ignored = 1'b1;
               nx.reply_valid = 1'b0;
            end else if (c_sum != st.cmd_sum) begin
               nx.rep_status = `PCH_ST_CHECKSUM;
            end else begin
               case (c_op)
                  `PCH_OP_SET_AXIS: begin
                     if (c_bank != 8'h00) begin
                        nx.rep_status = `PCH_ST_BAD_VALUE;
                     end else begin
                        // Volatile only; nothing goes to the save port
                        mem_we = 1'b1;
                        mem_waddr = {`PCH_RG_AXIS, c_type};
                        mem_wdata = st.cmd_value;
                     end
                  end
                  `PCH_OP_GET_AXIS: begin
                     if (c_bank != 8'h00) begin
                        nx.rep_status = `PCH_ST_BAD_VALUE;
                     end else begin
                        mem_raddr = {`PCH_RG_AXIS, c_type};
                        nx.kind = PCH_FK_AXIS;
                        nx.state = PCH_FETCH;
                        nx.reply_valid = 1'b0;
                     end
                  end
                  `PCH_OP_SET_GLOBAL: begin
                     if (!bank_ok(c_bank)) begin
                        nx.rep_status = `PCH_ST_BAD_VALUE;
                     end else begin
                        mem_we = 1'b1;
                        mem_waddr = {bank_region(c_bank), c_type};
                        mem_wdata = st.cmd_value;
                        if (c_bank == `PCH_BANK_MODULE) begin
                           nx.nv_valid = 1'b1;
                           nx.nv_index = c_type;
                           nx.nv_data = st.cmd_value;
                           if (c_type == `PCH_GP_SERIAL) begin
                              nx.serial = st.cmd_value[7:0];
                           end
                        end
                     end
                  end
                  `PCH_OP_GET_GLOBAL: begin
                     if (!bank_ok(c_bank)) begin
                        nx.rep_status = `PCH_ST_BAD_VALUE;
                     end else if (c_bank == `PCH_BANK_MODULE && c_type == `PCH_GP_SERIAL) begin
                        nx.accu = {24'h0, st.serial};
                        nx.rep_value = {24'h0, st.serial};
                     end else begin
                        mem_raddr = {bank_region(c_bank), c_type};
                        nx.kind = PCH_FK_GLOBAL;
                        nx.state = PCH_FETCH;
                        nx.reply_valid = 1'b0;
                     end
                  end
                  `PCH_OP_MOVE: begin
                     if (c_type != `PCH_MOVE_STORED) begin
                        nx.rep_status = `PCH_ST_BAD_TYPE;
                     end else if (c_bank != 8'h00 || st.cmd_value > `PCH_POINT_MAX) begin
                        nx.rep_status = `PCH_ST_BAD_VALUE;
                     end else begin
                        // Host must have stored this point beforehand
                        mem_raddr = {`PCH_RG_POINT, st.cmd_value[7:0]};
                        nx.kind = PCH_FK_MOVE;
                        nx.state = PCH_FETCH;
                        nx.reply_valid = 1'b0;
                     end
                  end
                  default: nx.rep_status = `PCH_ST_BAD_CMD;
               endcase
            end
         end
         PCH_FETCH: begin
            nx.state = PCH_IDLE;
            nx.reply_valid = 1'b1;
            case (st.kind)
               PCH_FK_AXIS: begin
                  nx.rep_value = rd_data;
                  if (st.standalone) begin
                     nx.accu = rd_data;
                  end
               end
               PCH_FK_GLOBAL: begin
                  nx.rep_value = rd_data;
                  nx.accu = rd_data;
               end
               default: begin
                  nx.move_start = 1'b1;
                  nx.move_target = rd_data;
               end
            endcase
         end
         default: nx.state = PCH_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.state <= PCH_IDLE;
         st.kind <= PCH_FK_AXIS;
         st.serial <= `PCH_SERIAL_RST;
      end else begin
         st <= nx;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bresp = st.bresp;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_arready = st.arready;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rvalid = st.rvalid;
   assign nv_save_valid = st.nv_valid;
   assign nv_save_index = st.nv_index;
   assign nv_save_data = st.nv_data;
   assign move_start = st.move_start;
   assign move_target = st.move_target;

   logic exec_ok;
   assign exec_ok = st.state == PCH_EXEC && c_addr == st.serial && c_sum == st.cmd_sum;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence move_req_s;
      exec_ok && c_op == `PCH_OP_MOVE && c_type == `PCH_MOVE_STORED && c_bank == 8'h00
         && st.cmd_value <= `PCH_POINT_MAX;
   endsequence
   sequence move_done_s;
      st.state == PCH_FETCH ##1 (move_start && move_target == $past(rd_data)
         && st.rep_status == `PCH_ST_OK);
   endsequence

   axis_write_a: assert property (exec_ok && c_op == `PCH_OP_SET_AXIS && c_bank == 8'h00
      |-> mem_we && mem_waddr == {`PCH_RG_AXIS, c_type} && mem_wdata == st.cmd_value)
      else $error("set axis did not write the axis parameter");
   axis_reply_a: assert property (exec_ok && c_op == `PCH_OP_GET_AXIS && c_bank == 8'h00
      ##1 1'b1 |=> st.reply_valid && st.rep_status == `PCH_ST_OK && st.rep_value == $past(rd_data))
      else $error("get axis reply wrong");
   accu_direct_a: assert property (st.state == PCH_FETCH && st.kind == PCH_FK_AXIS
      && !st.standalone |=> $stable(st.accu))
      else $error("direct mode read touched accumulator");
   accu_standalone_a: assert property (st.state == PCH_FETCH && st.kind == PCH_FK_AXIS
      && st.standalone |=> st.accu == $past(rd_data))
      else $error("standalone read did not load accumulator");
   global_accu_a: assert property (st.state == PCH_FETCH && st.kind == PCH_FK_GLOBAL
      |=> st.accu == $past(rd_data))
      else $error("get global did not load accumulator");
   nv_save_a: assert property (exec_ok && c_op == `PCH_OP_SET_GLOBAL && c_bank == 8'h00
      |=> nv_save_valid && nv_save_data == $past(st.cmd_value) ##1 !nv_save_valid)
      else $error("bank 0 write not saved once");
   serial_update_a: assert property (exec_ok && c_op == `PCH_OP_SET_GLOBAL
      && c_bank == 8'h00 && c_type == `PCH_GP_SERIAL |=> st.serial == $past(st.cmd_value[7:0]))
      else $error("serial address not updated");
   bank_reject_a: assert property (exec_ok && c_op == `PCH_OP_SET_GLOBAL
      && !bank_ok(c_bank) |-> !mem_we ##1 st.rep_status == `PCH_ST_BAD_VALUE)
      else $error("invalid bank not rejected");
   checksum_bad_a: assert property (st.state == PCH_EXEC && c_addr == st.serial
      && c_sum != st.cmd_sum |-> !mem_we ##1 st.rep_status == `PCH_ST_CHECKSUM && st.reply_valid)
      else $error("bad checksum not rejected");
   addr_ignore_a: assert property (st.state == PCH_EXEC && c_addr != st.serial
      |-> !mem_we && !mem_raddr[0] ##1 st.ignored && !st.reply_valid && !nv_save_valid)
      else $error("foreign command not ignored");
   point_move_a: assert property (move_req_s |=> move_done_s)
      else $error("stored point move not issued");
endmodule : pch_top

/* File: test/pch_host.sv */
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_host (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output pch_pkg::pch_word_t s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire pch_pkg::pch_word_t s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   import pch_pkg::*;
   // Cycles the host lingers before taking an answer
   int stall = 0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   task automatic wr(input logic [7:0] a, input pch_word_t d, output logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk);
         // Released lines show garbage so stale values cannot pass
         if (s_axi_awready && !ad) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wready && !dd) begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      repeat (stall) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output pch_word_t d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      repeat (stall) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic cmd(input logic [7:0] tg, op, ty, bk, input pch_word_t v, input logic [7:0] sk);
      logic [7:0] s;
      logic [1:0] r;
      s = tg + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + sk;
      wr(`PCH_A_CMD_HEAD, {tg, op, ty, bk}, r);
      wr(`PCH_A_CMD_VALUE, v, r);
      wr(`PCH_A_CMD_CHECK, {24'h0, s}, r);
   endtask : cmd
endmodule : pch_host

/* File: test/tb_parameter_command_handler.sv */
`timescale 1ns/1ns
`include "pch_defines.svh"
module tb_parameter_command_handler;
   import pch_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr, nv_save_index, ty, bk, ser, nv_i;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nv_save_valid, move_start;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   pch_word_t s_axi_wdata, s_axi_rdata, nv_save_data, move_target, dv, v, accu_e, nv_d;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   int nv_cnt = 0;
   int mv_cnt = 0;
   int n0;
   integer seed = 32'he61b03bb;
   logic [7:0] banks[4] = '{8'h00, 8'h02, 8'h03, 8'h01};
   logic [7:0] pts[3] = '{8'h08, 8'h14, 8'h15};
   pch_top pch_top_inst (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .nv_save_valid, .nv_save_index, .nv_save_data, .move_start,
      .move_target);
   pch_host pch_host_inst (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   always #2 clk = ~clk;
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cycles++;
      if (nv_save_valid === 1'b1) begin
         nv_cnt++;
         nv_d = nv_save_data;
         nv_i = nv_save_index;
      end
      if (move_start === 1'b1) mv_cnt++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic chk(input string n, input pch_word_t e, input pch_word_t g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input string n, input logic [7:0] a, input pch_word_t e);
      pch_host_inst.rd(a, dv, rr);
      chk(n, e, dv);
   endtask : rchk
   function automatic logic [7:0] est(input logic [7:0] op, ty, bk, input pch_word_t val);
      if (op == `PCH_OP_SET_AXIS || op == `PCH_OP_GET_AXIS)
         return (bk == 8'h00) ? `PCH_ST_OK : `PCH_ST_BAD_VALUE;
      if (op == `PCH_OP_SET_GLOBAL || op == `PCH_OP_GET_GLOBAL)
         return (bk inside {8'h00, 8'h02, 8'h03}) ? `PCH_ST_OK : `PCH_ST_BAD_VALUE;
      if (op == `PCH_OP_MOVE) begin
         if (ty != `PCH_MOVE_STORED) return `PCH_ST_BAD_TYPE;
         return (bk == 8'h00 && val <= `PCH_POINT_MAX) ? `PCH_ST_OK : `PCH_ST_BAD_VALUE;
      end
      return `PCH_ST_BAD_CMD;
   endfunction : est
   task automatic run(input logic [7:0] tg, op, t, b, input pch_word_t val, input logic [7:0] sk,
                      input logic ign);
      int n;
      logic [7:0] e;
      e = (sk != 8'h00) ? `PCH_ST_CHECKSUM : est(op, t, b, val);
      pch_host_inst.cmd(tg, op, t, b, val, sk);
      n = 0;
      do begin
         pch_host_inst.rd(`PCH_A_STATUS, dv, rr);
         n++;
      end while (dv[0] !== 1'b0 && n < 20);
      if (ign) begin
         chk("ignored flags", 32'h0000_0004, dv & 32'h0000_0007);
      end else begin
         chk("reply flags", 32'h0000_0002, dv & 32'h0000_0007);
         rchk("reply status", `PCH_A_REP_STATUS, {24'h0, e});
      end
   endtask : run
   initial begin
      ser = 8'h01;
      accu_e = 32'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("status at reset", `PCH_A_STATUS, 32'h0000_0100);
      rchk("accu at reset", `PCH_A_ACCU, accu_e);
      for (int i = 0; i < 8; i++) begin
         ty = 8'($random(seed));
         v = $random(seed);
         pch_host_inst.stall = i % 3;
         run(ser, `PCH_OP_SET_AXIS, ty, 8'h00, v, 8'h00, 1'b0);
         run(ser, `PCH_OP_GET_AXIS, ty, 8'h00, $random(seed), 8'h00, 1'b0);
         rchk("axis value", `PCH_A_REP_VALUE, v);
         rchk("accu direct", `PCH_A_ACCU, accu_e);
      end
      chk("axis saves", 32'h0, 32'(nv_cnt));
      run(ser, `PCH_OP_SET_AXIS, ty, 8'h01, v, 8'h00, 1'b0);
      pch_host_inst.wr(`PCH_A_CONFIG, 32'h1, rr);
      chk("config write", {30'h0, `PCH_RESP_OKAY}, {30'h0, rr});
      rchk("config", `PCH_A_CONFIG, 32'h1);
      run(ser, `PCH_OP_GET_AXIS, ty, 8'h00, 32'h0, 8'h00, 1'b0);
      accu_e = v;
      rchk("accu standalone", `PCH_A_ACCU, accu_e);
      pch_host_inst.wr(`PCH_A_CONFIG, 32'h0, rr);
      for (int i = 0; i < 4; i++) begin
         bk = banks[i];
         // Types below 64 keep the serial address out of the random set
         ty = 8'($random(seed)) & 8'h3F;
         v = $random(seed);
         n0 = nv_cnt;
         run(ser, `PCH_OP_SET_GLOBAL, ty, bk, v, 8'h00, 1'b0);
         chk("bank saves", 32'(n0 + (bk == 8'h00)), 32'(nv_cnt));
         if (bk == 8'h00) chk("saved data", v, nv_d);
         if (bk == 8'h00) chk("saved index", {24'h0, ty}, {24'h0, nv_i});
         run(ser, `PCH_OP_GET_GLOBAL, ty, bk, ~v, 8'h00, 1'b0);
         if (bk != 8'h01) accu_e = v;
         rchk("accu global", `PCH_A_ACCU, accu_e);
      end
      run(ser, `PCH_OP_SET_GLOBAL, `PCH_GP_SERIAL, 8'h00, 32'h3, 8'h00, 1'b0);
      ser = 8'h03;
      rchk("serial field", `PCH_A_STATUS, 32'h0000_0302);
      run(8'h01, `PCH_OP_SET_AXIS, 8'h04, 8'h00, 32'hC800, 8'h00, 1'b1);
      run(ser, `PCH_OP_GET_GLOBAL, `PCH_GP_SERIAL, 8'h00, 32'h0, 8'h00, 1'b0);
      rchk("serial value", `PCH_A_REP_VALUE, 32'h3);
      rchk("accu serial", `PCH_A_ACCU, 32'h3);
      run(ser, `PCH_OP_SET_AXIS, 8'h04, 8'h00, v, 8'h01, 1'b0);
      run(ser, 8'h07, 8'h00, 8'h00, 32'h0, 8'h00, 1'b0);
      for (int i = 0; i < 3; i++) begin
         v = $random(seed);
         pch_host_inst.wr(`PCH_A_POINT_IDX, {24'h0, pts[i]}, rr);
         pch_host_inst.wr(`PCH_A_POINT_DATA, v, rr);
         n0 = mv_cnt;
         run(ser, `PCH_OP_MOVE, `PCH_MOVE_STORED, 8'h00, {24'h0, pts[i]}, 8'h00, 1'b0);
         chk("moves", 32'(n0 + (pts[i] <= 8'h14)), 32'(mv_cnt));
         if (pts[i] <= 8'h14) chk("move target", v, move_target);
      end
      run(ser, `PCH_OP_MOVE, 8'h01, 8'h00, 32'h8, 8'h00, 1'b0);
      chk("moves after bad type", 32'(n0), 32'(mv_cnt));
      pch_host_inst.rd(8'h30, dv, rr);
      chk("unmapped response", {30'h0, `PCH_RESP_SLVERR}, {30'h0, rr});
      pch_host_inst.wr(8'h30, v, rr);
      chk("unmapped write", {30'h0, `PCH_RESP_SLVERR}, {30'h0, rr});
      conclude();
   end
endmodule : tb_parameter_command_handler
